// ### logic/cmd_pkg.sv
// Package with the constants and carrier types of the console memory decode block.
package cmd_pkg;
  // ----------------------------------------------------------------------
  // Address map and decode constants
  // ----------------------------------------------------------------------
  localparam logic [4:0] TIMER_HI_ADDR = 5'h03;
  localparam logic [15:0] ROM_LAST_ADDR = 16'h17ff;
  localparam logic [15:0] RAM_FIRST_ADDR = 16'h4000;
  localparam logic [15:0] RAM_LAST_ADDR = 16'h7fff;
  localparam int ROM_BANK_LSB = 11;
  localparam int ROM_MUX_SEL_BIT = 13;
  localparam int RAM_SEL_BIT = 14;
  localparam int CPU_REG_BIT = 15;
  localparam int ROW_BITS = 7;
  localparam logic [6:0] REFR_CNT_RESET = 7'h00;

  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int REFR_PERIOD_NS = 12800;
  localparam int REFR_LIMIT_US = 2000;
  localparam int ROW_COUNT = 128;
  // Row strobe held this long, rounded up, at least one cycle.
  localparam int ROW_STB_NS = 40;
  localparam int ROW_STB_CYC = (ROW_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_STB_NS = 40;
  localparam int COL_STB_CYC = (COL_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STB_CNT_W = 4;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rom_output_mux_select;
    logic sel_status;
    logic ctrl_store_wr_reg_strobe;
    logic sel_timer;
    logic cmd_reg0_write_strobe;
    logic cmd_reg1_write_strobe;
    logic sel_cpu_regs;
    logic rom_sel_ready;
  } cmd_selects_t;

  typedef struct packed {
    logic dram_row_strobe;
    logic dram_column_strobe;
    logic dram_write_enable;
    logic [6:0] dram_addr;
  } cmd_dram_t;
endpackage

// ### logic/cmd_decode.sv
// Combinational select decoder for processor memory and I/O references.
`timescale 1ns/1ns
module cmd_decode (
  input wire logic i_io,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:8] i_addr_hi,
  output cmd_pkg::cmd_selects_t o_sel
);
  // ----------------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------------
  // Upper five address lines drive every decision.
  logic [4:0] top;
  assign top = i_addr_hi[15:11];

  // One process builds every select; all but rom_sel_ready use the I/O flag, and sel_timer ignores the strobes.
  always_comb begin
    o_sel = '0;
    // ROM space reads, and ready summary read, both use the mux.
    o_sel.rom_output_mux_select = i_rd & ((!i_io & top[4:2] == 3'h0) |
                        (i_io & top == 5'h04));
    o_sel.rom_sel_ready = i_addr_hi[cmd_pkg::ROM_MUX_SEL_BIT];
    o_sel.sel_status = i_io & i_rd & (top == 5'h00);
    o_sel.ctrl_store_wr_reg_strobe = i_io & i_wr & (top == 5'h01);
    o_sel.sel_timer = i_io & !top[4] & (top[2:0] == cmd_pkg::TIMER_HI_ADDR[2:0]);
    o_sel.cmd_reg0_write_strobe = i_io & i_wr & (top[4:1] == 4'h2);
    o_sel.cmd_reg1_write_strobe = i_io & i_wr & (top[4:1] == 4'h3);
    o_sel.sel_cpu_regs = i_io & top[4] & (i_wr | (i_rd & top[3:0] == 4'h0));
  end
endmodule

// ### logic/cmd_mem_ctrl.sv
// Main memory decode, ROM addressing and dynamic RAM controller for the console processor.
`timescale 1ns/1ns
module cmd_mem_ctrl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_address_latch_strobe,
  input wire logic i_io,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_ram_write_cycle,
  input wire logic [15:8] i_addr_hi,
  input wire logic [7:0] i_buffered_addr_data_bus,
  input wire logic [7:0] i_rom_data,
  input wire logic [7:0] i_ready_summary,
  input wire logic i_usart_busy,
  input wire logic i_refresh_request,
  output logic [7:0] o_mux_data,
  output logic o_mux_data_oe,
  output cmd_pkg::cmd_selects_t o_sel,
  output logic [1:0] o_rom_bank,
  output logic [10:0] o_rom_addr,
  output cmd_pkg::cmd_dram_t o_dram,
  output logic o_ready,
  output logic o_inserted_wait_state,
  output logic o_refresh_cycle_ff,
  output logic o_ctrl_store_refresh_trigger
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The refresh period must let all rows pass inside the retention limit.
  if (cmd_pkg::ROW_COUNT * cmd_pkg::REFR_PERIOD_NS > cmd_pkg::REFR_LIMIT_US * 1000) begin : g_chk
    $error("Refresh period too long for the row count");
  end
  // A zero-cycle strobe width is refused; the timer itself stops at zero and never wraps.
  if (cmd_pkg::ROW_STB_CYC < 1 || cmd_pkg::COL_STB_CYC < 1) begin : g_chk_stb
    $error("Strobe widths must span at least one cycle");
  end
  // The strobe timer must hold the longest count that it is loaded with.
  if (cmd_pkg::ROW_STB_CYC >= (1 << cmd_pkg::STB_CNT_W) ||
      cmd_pkg::COL_STB_CYC >= (1 << cmd_pkg::STB_CNT_W)) begin : g_chk_tmr
    $error("Strobe timer too narrow for the strobe widths");
  end
  // The refresh counter and the array address are seven bits, one value per row.
  if (cmd_pkg::ROW_BITS != 7 || cmd_pkg::ROW_COUNT != (1 << cmd_pkg::ROW_BITS)) begin : g_chk_row
    $error("Row count does not match the seven-bit row address");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // The address strobe, refresh request and USART busy pins pass two flops; only stage two is read.
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [NSYNC-1:0] raw_in;
  logic ale_s, req_s, usart_s;
  logic ale_d_reg, ale_d_next, req_d_reg, req_d_next;

  // Sequencing uses the synchronised strobe; the latch follows the raw strobe level.
  assign raw_in = {i_address_latch_strobe, i_refresh_request, i_usart_busy};
  assign ale_s = sync2_reg[2];
  assign req_s = sync2_reg[1];
  assign usart_s = sync2_reg[0];

  // Next values for the synchroniser chain and edge history.
  always_comb begin
    sync1_next = raw_in;
    sync2_next = sync1_reg;
    ale_d_next = ale_s;
    req_d_next = req_s;
  end

  // Registers of the synchroniser chain.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ale_d_reg <= 1'b0;
      req_d_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      ale_d_reg <= ale_d_next;
      req_d_reg <= req_d_next;
    end
  end

  // History flops reset to the idle low level, so no false edge follows reset.
  logic ale_fall, req_rise, req_fall;
  assign ale_fall = ale_d_reg & !ale_s;
  assign req_rise = req_s & !req_d_reg;
  assign req_fall = !req_s & req_d_reg;

  // ----------------------------------------------------------------------
  // Select decode and address latch
  // ----------------------------------------------------------------------
  // Selects are registered below, so they lag their inputs by one cycle.
  cmd_pkg::cmd_selects_t sel_comb;

  cmd_decode u_decode (
    .i_io(i_io),
    .i_rd(i_rd),
    .i_wr(i_wr),
    .i_addr_hi(i_addr_hi),
    .o_sel(sel_comb)
  );

  // Low address byte is taken while the strobe is high, held afterwards.
  logic [7:0] lat_reg, lat_next;
  cmd_pkg::cmd_selects_t sel_reg, sel_next;
  logic [1:0] bank_reg, bank_next;
  logic [10:0] rom_addr_reg, rom_addr_next;
  logic [7:0] mux_reg, mux_next;
  logic mux_oe_reg, mux_oe_next;

  always_comb begin
    lat_next = lat_reg;
    if (i_address_latch_strobe) begin
      lat_next = i_buffered_addr_data_bus;
    end
    sel_next = sel_comb;
    bank_next = i_addr_hi[cmd_pkg::ROM_BANK_LSB+1:cmd_pkg::ROM_BANK_LSB];
    rom_addr_next = {i_addr_hi[10:8], lat_reg};
    // Driving waits until the strobe has dropped, so the address is gone.
    mux_oe_next = sel_comb.rom_output_mux_select & !i_address_latch_strobe;
    mux_next = sel_comb.rom_sel_ready ? i_ready_summary : i_rom_data;
  end

  // Every select, bank and mux value is a flop, so the outputs carry no decode glitch.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lat_reg <= 8'h00;
      sel_reg <= '0;
      bank_reg <= 2'h0;
      rom_addr_reg <= 11'h000;
      mux_reg <= 8'h00;
      mux_oe_reg <= 1'b0;
    end else begin
      lat_reg <= lat_next;
      sel_reg <= sel_next;
      bank_reg <= bank_next;
      rom_addr_reg <= rom_addr_next;
      mux_reg <= mux_next;
      mux_oe_reg <= mux_oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // DRAM sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REFR,
    ST_ROW,
    ST_COL,
    ST_DONE
  } cmd_state_t;

  // Sequencer state, refresh bookkeeping and strobe timing.
  cmd_state_t state_reg, state_next;
  logic start_reg, start_next; // cycle-start flop
  logic pend_reg, pend_next; // refresh waiting to run
  logic refr_reg, refr_next;
  logic csr_reg, csr_next; // control store trigger flop
  logic row_sel_reg, row_sel_next; // address mux shows row when high
  logic [6:0] rcnt_reg, rcnt_next;
  logic [cmd_pkg::STB_CNT_W-1:0] tmr_reg, tmr_next;
  cmd_pkg::cmd_dram_t dram_reg, dram_next;
  logic ready_reg, ready_next;
  logic wait_reg, wait_next;
  logic ram_ref;
  logic [6:0] row_addr, col_addr;

  // Picks every second bit of the fourteen-bit array address, from bit 13 or bit 12 down.
  // Row and column share one decode, so the two halves cannot drift apart.
  function automatic logic [6:0] pick_bits(input logic [13:0] addr, input logic row);
    logic [6:0] bits;
    bits = '0;
    for (int k = 0; k < 7; k++) begin
      bits[k] = row ? addr[2*k+1] : addr[2*k];
    end
    return bits;
  endfunction

  // A RAM reference is a memory cycle with line 14 high and line 15 low.
  assign ram_ref = !i_io & i_addr_hi[cmd_pkg::RAM_SEL_BIT] & !i_addr_hi[cmd_pkg::CPU_REG_BIT];
  assign row_addr = pick_bits({i_addr_hi[13:8], lat_reg}, 1'b1);
  assign col_addr = pick_bits({i_addr_hi[13:8], lat_reg}, 1'b0);

  // One refresh strobe per request period keeps all rows inside the limit.
  always_comb begin
    state_next = state_reg;
    start_next = start_reg;
    pend_next = pend_reg | req_rise;
    refr_next = refr_reg;
    csr_next = csr_reg;
    row_sel_next = row_sel_reg;
    rcnt_next = rcnt_reg;
    tmr_next = tmr_reg;
    dram_next = dram_reg;
    dram_next.dram_write_enable = i_ram_write_cycle & ram_ref;
    // The cycle-start flop is set once per RAM reference, as the address strobe ends.
    if (ale_fall & ram_ref) begin
      start_next = 1'b1;
    end
    // Set wins over clear: the request fall only clears if refresh is idle.
    if (refr_reg) begin
      csr_next = 1'b1;
    end else if (req_fall) begin
      csr_next = 1'b0;
    end
    unique case (state_reg)
      // The address mux rests on the row address while idle.
      ST_IDLE: begin
        row_sel_next = 1'b1;
        dram_next.dram_addr = row_addr;
        // A USART transfer in flight defers the refresh; the request waits in pend_reg.
        if ((pend_reg | req_rise) & !usart_s) begin
          // A pending refresh runs before a RAM access that is starting.
          state_next = ST_REFR;
          refr_next = 1'b1;
          pend_next = 1'b0;
          dram_next.dram_addr = rcnt_reg;
          dram_next.dram_row_strobe = 1'b1;
          tmr_next = cmd_pkg::STB_CNT_W'(cmd_pkg::ROW_STB_CYC);
        end else if (start_reg) begin
          state_next = ST_ROW;
          dram_next.dram_row_strobe = 1'b1;
          tmr_next = cmd_pkg::STB_CNT_W'(cmd_pkg::ROW_STB_CYC);
        end
      end
      // The trailing edge of the refresh flop advances the row counter.
      ST_REFR: begin
        if (tmr_reg == '0) begin
          state_next = ST_IDLE;
          refr_next = 1'b0;
          dram_next.dram_row_strobe = 1'b0;
          rcnt_next = rcnt_reg + 7'h01;
        end else begin
          tmr_next = tmr_reg - cmd_pkg::STB_CNT_W'(1);
        end
      end
      // Row strobe stands while the mux moves over to the column address.
      ST_ROW: begin
        row_sel_next = 1'b0;
        dram_next.dram_addr = col_addr;
        // The column strobe stays off until the mux has left the row address.
        if (tmr_reg == '0 && !row_sel_reg) begin
          state_next = ST_COL;
          dram_next.dram_column_strobe = 1'b1;
          tmr_next = cmd_pkg::STB_CNT_W'(cmd_pkg::COL_STB_CYC);
        end else if (tmr_reg != '0) begin
          tmr_next = tmr_reg - cmd_pkg::STB_CNT_W'(1);
        end
      end
      // Both strobes stand while the array reads or writes.
      ST_COL: begin
        if (tmr_reg == '0) begin
          state_next = ST_DONE;
          start_next = 1'b0;
        end else begin
          tmr_next = tmr_reg - cmd_pkg::STB_CNT_W'(1);
        end
      end
      ST_DONE: begin
        // Strobes drop when the processor ends the cycle.
        if (!(i_rd | i_wr)) begin
          state_next = ST_IDLE;
          dram_next.dram_row_strobe = 1'b0;
          dram_next.dram_column_strobe = 1'b0;
        end
      end
    endcase
    // Long cycle holds ready low while the access, or a refresh ahead of it, runs.
    ready_next = !(start_next | (state_next == ST_REFR & start_reg));
    wait_next = !ready_next;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      pend_reg <= 1'b0;
      refr_reg <= 1'b0;
      csr_reg <= 1'b0;
      row_sel_reg <= 1'b1;
      rcnt_reg <= cmd_pkg::REFR_CNT_RESET;
      tmr_reg <= '0;
      dram_reg <= '0;
      ready_reg <= 1'b1;
      wait_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
      pend_reg <= pend_next;
      refr_reg <= refr_next;
      csr_reg <= csr_next;
      row_sel_reg <= row_sel_next;
      rcnt_reg <= rcnt_next;
      tmr_reg <= tmr_next;
      dram_reg <= dram_next;
      ready_reg <= ready_next;
      wait_reg <= wait_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a flop; the wait flag has its own rather than an inverter on ready.
  assign o_mux_data = mux_reg;
  assign o_mux_data_oe = mux_oe_reg;
  assign o_sel = sel_reg;
  assign o_rom_bank = bank_reg;
  assign o_rom_addr = rom_addr_reg;
  assign o_dram = dram_reg;
  assign o_ready = ready_reg;
  assign o_inserted_wait_state = wait_reg;
  assign o_refresh_cycle_ff = refr_reg;
  assign o_ctrl_store_refresh_trigger = csr_reg;
endmodule

// ### tb/cmd_mem_ctrl_props.sv
// Concurrent checks on the ports of the memory decode and DRAM controller.
`timescale 1ns/1ns
module cmd_mem_ctrl_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_address_latch_strobe,
  input wire logic i_io,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_ram_write_cycle,
  input wire logic [15:8] i_addr_hi,
  input wire logic o_mux_data_oe,
  input wire cmd_pkg::cmd_selects_t o_sel,
  input wire cmd_pkg::cmd_dram_t o_dram,
  input wire logic o_ready,
  input wire logic o_inserted_wait_state,
  input wire logic o_refresh_cycle_ff,
  input wire logic o_ctrl_store_refresh_trigger
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [6:0] row_reg, row_next;
  logic seen_reg, seen_next, refr_reg;
  // ----------------------------------------------------------------
  // Refresh row tracking
  // ----------------------------------------------------------------
  // Keeps the last refreshed row so that the wrap-around step can be judged.
  always_comb begin
    row_next = row_reg;
    seen_next = seen_reg;
    if (o_refresh_cycle_ff && !refr_reg) begin
      row_next = o_dram.dram_addr;
      seen_next = 1'b1;
    end
  end
  // Cleared by reset, because the counter restarts from row zero.
  always_ff @(posedge i_clk) begin
    row_reg <= i_sys_rst ? 7'h00 : row_next;
    seen_reg <= i_sys_rst ? 1'b0 : seen_next;
    refr_reg <= i_sys_rst ? 1'b0 : o_refresh_cycle_ff;
  end
  sequence refr_hold_s;
    o_refresh_cycle_ff [*6] ##1 !o_refresh_cycle_ff;
  endsequence
  sequence col_follow_s;
    ##[3:8] $rose(o_dram.dram_column_strobe);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  timer_sel_a: assert property (i_io && i_addr_hi[15:11] == cmd_pkg::TIMER_HI_ADDR
    |=> o_sel.sel_timer) else $error("timer select missing");
  rom_sel_a: assert property (!i_io && i_rd && i_addr_hi[15:13] == 3'h0
    |=> o_sel.rom_output_mux_select) else $error("rom mux select missing");
  cpu_sel_a: assert property (i_io && i_wr && i_addr_hi[15]
    |=> o_sel.sel_cpu_regs) else $error("cpu register select missing");
  bus_release_a: assert property (i_address_latch_strobe |=> !o_mux_data_oe)
    else $error("mux drives bus during address phase");
  ram_wait_a: assert property ($rose(o_dram.dram_row_strobe) && !o_refresh_cycle_ff
    |-> !o_ready && o_inserted_wait_state) else $error("no wait state on access");
  row_to_col_a: assert property ($rose(o_dram.dram_row_strobe) && !o_refresh_cycle_ff
    |-> col_follow_s) else $error("column strobe not after row strobe");
  col_row_a: assert property (o_dram.dram_column_strobe |-> o_dram.dram_row_strobe)
    else $error("column strobe without row strobe");
  we_follow_a: assert property (o_dram.dram_column_strobe && !o_refresh_cycle_ff &&
    $stable(i_ram_write_cycle) |-> o_dram.dram_write_enable == i_ram_write_cycle)
    else $error("write enable differs from write cycle");
  refr_len_a: assert property ($rose(o_refresh_cycle_ff) |-> refr_hold_s)
    else $error("refresh cycle length wrong");
  refr_row_a: assert property (o_refresh_cycle_ff && !refr_reg |-> o_dram.dram_row_strobe &&
    o_dram.dram_addr == (seen_reg ? row_reg + 7'h01 : 7'h00)) else $error("refresh row wrong");
  trig_set_a: assert property ($rose(o_refresh_cycle_ff) |=> o_ctrl_store_refresh_trigger)
    else $error("control store trigger not set");
endmodule
bind cmd_mem_ctrl cmd_mem_ctrl_props chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_address_latch_strobe(i_address_latch_strobe), .i_io(i_io), .i_rd(i_rd), .i_wr(i_wr),
  .i_ram_write_cycle(i_ram_write_cycle), .i_addr_hi(i_addr_hi), .o_mux_data_oe(o_mux_data_oe),
  .o_sel(o_sel), .o_dram(o_dram), .o_ready(o_ready), .o_inserted_wait_state(o_inserted_wait_state),
  .o_refresh_cycle_ff(o_refresh_cycle_ff),
  .o_ctrl_store_refresh_trigger(o_ctrl_store_refresh_trigger));

// ### tb/cmd_far_model.sv
// ROM banks and ready summary register that feed the output multiplexer.
`timescale 1ns/1ns
module cmd_far_model #(
  parameter logic [7:0] SUMMARY = 8'h5a
) (
  input wire logic [1:0] i_rom_bank,
  input wire logic [10:0] i_rom_addr,
  output logic [7:0] o_rom_data,
  output logic [7:0] o_ready_summary
);
  // Contents mix in the bank so a wrong bank shows as wrong data.
  assign o_rom_data = i_rom_addr[7:0] ^ {6'h00, i_rom_bank};
  assign o_ready_summary = SUMMARY;
endmodule

// ### tb/test_cmd_mem_ctrl.sv
// Self-checking testbench of the memory decode and DRAM controller.
`timescale 1ns/1ns
module test_cmd_mem_ctrl;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, ale = 1'b0, io = 1'b0, rd = 1'b0, wr = 1'b0;
  logic wcyc = 1'b0, busy = 1'b0, req = 1'b0, mux_oe, rdy, tw, refr, trig;
  logic [7:0] ahi = 8'h00, bus = 8'h00, mux_data, rom_d, rsum;
  logic [1:0] bank;
  logic [10:0] raddr;
  cmd_pkg::cmd_selects_t sel;
  cmd_pkg::cmd_dram_t dram;
  int num_errors = 0, n_checks = 0, cyc = 0;
  cmd_mem_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address_latch_strobe(ale),
    .i_io(io), .i_rd(rd), .i_wr(wr), .i_ram_write_cycle(wcyc), .i_addr_hi(ahi),
    .i_buffered_addr_data_bus(bus), .i_rom_data(rom_d), .i_ready_summary(rsum),
    .i_usart_busy(busy), .i_refresh_request(req), .o_mux_data(mux_data),
    .o_mux_data_oe(mux_oe), .o_sel(sel), .o_rom_bank(bank), .o_rom_addr(raddr),
    .o_dram(dram), .o_ready(rdy), .o_inserted_wait_state(tw), .o_refresh_cycle_ff(refr),
    .o_ctrl_store_refresh_trigger(trig));
  cmd_far_model far_u (.i_rom_bank(bank), .i_rom_addr(raddr), .o_rom_data(rom_d),
    .o_ready_summary(rsum));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Runs the clock; the ceiling is far above the roughly 2200 cycles the tests need.
  initial forever #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic ticks(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address phase; afterwards the released bus shows the inverse, not the old byte.
  task automatic start(input logic [7:0] a, input logic [7:0] lo);
    ahi = a;
    bus = lo;
    ale = 1'b1;
    ticks(2);
    ale = 1'b0;
    ticks(1);
    bus = ~lo;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_decode();
    logic [2:0] c [12] = '{3'h2, 3'h6, 3'h6, 3'h5, 3'h5, 3'h6, 3'h5, 3'h5, 3'h5, 3'h6, 3'h2, 3'h6};
    logic [7:0] a [12] = '{8'h05, 8'h20, 8'h03, 8'h08, 8'h1c, 8'h1d, 8'h25, 8'h31, 8'ha3,
      8'h80, 8'h20, 8'h41};
    logic [6:0] e [12] = '{7'h40, 7'h40, 7'h20, 7'h10, 7'h08, 7'h08, 7'h04, 7'h02, 7'h01,
      7'h01, 7'h00, 7'h00};
    for (int i = 0; i < 12; i++) begin
      {io, rd, wr} = c[i];
      ahi = a[i];
      ticks(2);
      chk(sel, {e[i], a[i][5]});
    end
    {io, rd, wr} = 3'h0;
  endtask
  task automatic t_rom();
    start(8'h15, 8'ha7);
    rd = 1'b1;
    ticks(3);
    chk(bank, 2'h2);
    chk(raddr, 11'h5a7);
    chk(mux_data, 8'ha5);
    chk(mux_oe, 1'b1);
    io = 1'b1;
    ahi = 8'h20;
    ticks(3);
    chk(mux_data, 8'h5a);
    {io, rd} = 2'h0;
    ticks(3);
  endtask
  task automatic refresh(input logic [6:0] row);
    req = 1'b1;
    for (int k = 0; k < 40 && !refr; k++) @(negedge i_clk);
    chk({refr, dram.dram_row_strobe, dram.dram_addr}, {2'h3, row});
    ticks(8);
    chk({trig, refr}, 2'h2);
    req = 1'b0;
    ticks(5);
    chk(trig, 1'b0);
  endtask
  task automatic t_ram(input logic w, input logic pend);
    logic hit;
    hit = 1'b0;
    wcyc = w;
    req = pend;
    start(8'h6b, 8'h9c);
    {rd, wr} = {!w, w};
    for (int k = 0; k < 60 && !(dram.dram_row_strobe && !refr); k++) begin
      hit |= refr && !rdy;
      @(negedge i_clk);
    end
    chk({rdy, tw, dram.dram_addr}, 9'h0fa);
    for (int k = 0; k < 20 && !dram.dram_column_strobe; k++) @(negedge i_clk);
    chk({dram.dram_write_enable, dram.dram_addr}, {w, 7'h16});
    for (int k = 0; k < 20 && !rdy; k++) @(negedge i_clk);
    chk({rdy, hit}, {1'b1, pend});
    {rd, wr, wcyc, req} = 4'h0;
    ticks(12);
  endtask
  // Main sequence: reset values first, then each scenario in turn.
  initial begin
    ticks(3);
    chk({rdy, tw, dram, refr, trig}, 14'h2000);
    i_sys_rst = 1'b0;
    t_decode();
    t_rom();
    for (int i = 0; i < 129; i++) refresh(i[6:0]);
    busy = 1'b1;
    req = 1'b1;
    ticks(15);
    chk(refr, 1'b0);
    busy = 1'b0;
    refresh(7'h01);
    t_ram(1'b0, 1'b0);
    t_ram(1'b1, 1'b0);
    t_ram(1'b0, 1'b1);
    end_sim();
  end
endmodule
